// ==== ap_bus_model.sv ====
// Processor-side APB master that runs single read and write transfers
`timescale 1ns/1ps
`default_nettype none
module ap_bus_model (
    // Clock
    input wire logic clk,
    // Register bus
    output var irq_agg_pkg::apb_req_t apb_req,
    input wire irq_agg_pkg::apb_rsp_t apb_rsp
);
    import irq_agg_pkg::*;
    initial apb_req = '0;
    // Request held until pready; only the bench watchdog ends a wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '{1'b0, 1'b0, w, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ==== irq_agg_pkg.sv ====
// Package: event and sense positions, timing constants, register map, carriers
package irq_agg_pkg;

    // ************************************************************
    // Event bit positions in the status and mask vectors
    // ************************************************************
    typedef enum int unsigned {
        adc_finished_event, touch_conv_finished_event, touch_pen_event,
        vbus_overvoltage_event, battery_low_event, vbus_present_event,
        key_jam_recovered_event, key_jam_event, adc_result_change_event,
        unknown_accessory_event, remote_long_release_event, remote_long_press_event,
        remote_press_event, accessory_detach_event, accessory_attach_event,
        regulator_short_event, second_tick_event, clock_alarm_event,
        button_one_event, button_two_event, button_system_reset_event,
        watchdog_pin_restart_event, power_cut_event, warm_start_event,
        memory_hold_event, osc_source_change_event, timekeeping_reset_event,
        die_temp_first_event, die_temp_second_event, die_temp_third_event,
        die_temp_fourth_event, gp_pin_event, gp_pin_event_1, gp_pin_event_2,
        gp_pin_event_3, event_count
    } event_idx_t;

    // ************************************************************
    // Sense bit positions; the five aux bits sit together
    // ************************************************************
    typedef enum int unsigned {
        vbus_overvoltage_sense, vbus_present_sense, button_one_sense,
        button_two_sense, osc_source_crystal_sense, adc_result_sense,
        id_pin_grounded_sense, id_pin_open_sense, id_resistance_done_sense,
        vbus_detection_done_sense, die_temp_first_sense, die_temp_second_sense,
        die_temp_third_sense, die_temp_fourth_sense, gp_pin_sense, gp_pin_sense_1,
        gp_pin_sense_2, gp_pin_sense_3, sense_count
    } sense_idx_t;

    localparam int EVENT_W = event_count;
    localparam int SENSE_W = sense_count;
    localparam int AUX_W = 5;
    localparam int TEMP_N = 4;
    localparam int GP_N = 4;
    localparam int WORD_W = 32;

    // ************************************************************
    // Timing: the debounce time base is the 32.768 kHz oscillator
    // ************************************************************
    localparam longint OSC_HZ = 32768;
    localparam longint US_PER_S = 1000000;
    localparam int unsigned PEN_DB_US = 1000;
    localparam int unsigned SHORT_DB_US = 4000;
    localparam int unsigned SHORT_DB_MAX_US = 8000;
    localparam int unsigned BUTTON_DB_US = 30000;
    localparam int unsigned PROG_DB_US [4] = '{0, 1000, 4000, 16000};
    localparam int unsigned BUTTON_EXT_US [4] = '{0, 8000, 16000, 32000};
    localparam int DBNC_CNT_W = 12;
    localparam logic [2:0] PRIME_CYCLES = 3'h4;

    // ************************************************************
    // Register map (byte addresses) and reset values
    // ************************************************************
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] STATUS_LO_OFS = 8'h00;
    localparam logic [APB_ADDR_W-1:0] STATUS_HI_OFS = 8'h04;
    localparam logic [APB_ADDR_W-1:0] MASK_LO_OFS = 8'h08;
    localparam logic [APB_ADDR_W-1:0] MASK_HI_OFS = 8'h0c;
    localparam logic [APB_ADDR_W-1:0] SENSE_OFS = 8'h10;
    localparam logic [2*WORD_W-1:0] MASK_RESET = '1;

    typedef enum logic [2:0] {
        sel_status_lo, sel_status_hi, sel_mask_lo, sel_mask_hi, sel_sense, sel_none
    } reg_sel_t;

    // Power states as seen from the power sequencer
    typedef enum logic [3:0] {
        coin_cell, off_state, cold_start, watchdog, on_state, user_off_wait,
        memory_hold, user_off, warm_start, power_cut_hold
    } pwr_state_t;

    typedef enum logic [1:0] {rise_only, fall_only, either_edge, no_edge} gp_trig_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [WORD_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [WORD_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [1:0] overvoltage_debounce_sel;
        logic [1:0] battery_low_debounce_sel;
        logic [1:0] vbus_present_debounce_sel;
        logic [1:0] die_temp_debounce_sel;
        logic [1:0][1:0] button_falling_debounce_sel;
        logic [GP_N-1:0] gp_is_input;
        gp_trig_t [GP_N-1:0] gp_trigger_sel;
        logic [GP_N-1:0][1:0] gp_debounce_sel;
    } dbnc_cfg_t;

endpackage

// ==== pmic_event_irq_aggregator.sv ====
// Event aggregator: sync, debounce, latch, mask, one interrupt pin, APB registers
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ADC-done event latches on rising edge, no debounce.
// - Touch conversion done latches on rising edge, no debounce.
// - Pen detect latches on both edges after 1.0 ms stable.
// - VBUS over-voltage: both edges, selectable debounce, live sense bit.
// - Low battery latches on falling edge only, selectable debounce, no sense.
// - VBUS detect: both edges, selectable debounce, live sense bit.
// - Key, accessory, remote key and ADC change events latch on rising edge.
// - ADC status sense is 1 when conversion done, 0 while running.
// - Four sense-only ID and VBUS detection bits without events.
// - Regulator short latches on rising edge after 4 to 8 ms persistence.
// - Tick, alarm, reset, restart, cut, warm, hold, RTC reset: rising, no debounce.
// - Each power button latches both edges, 30 ms debounce, sense is pin level.
// - Per-button two-bit field lengthens the falling-edge debounce.
// - Clock source change latches both edges, no debounce; sense 1 for crystal.
// - Four die temperature events, both edges, selectable debounce, live sense.
// - Four general pins as inputs: selectable edge, debounce, mask and sense.
// - Interrupt pin stays low outside Watchdog and On states.
// - Register access only in Watchdog, On and User Off Wait states.
// - Event bits stay set until written with 1; pin stays if others pend.
// - Masks reset to 1; masked events still latch; unmask raises pin.
// - Pin high while any set event bit has its mask clear.
// - Sense bits are live, read-only; writes to them do nothing.
module pmic_event_irq_aggregator #(
    parameter int CNT_W = irq_agg_pkg::DBNC_CNT_W
) (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Register bus
    input wire irq_agg_pkg::apb_req_t apb_req,
    output var irq_agg_pkg::apb_rsp_t apb_rsp,
    // Raw sources, all asynchronous to clk
    input wire logic osc32k_in,
    input wire logic [irq_agg_pkg::EVENT_W-1:0] event_src,
    input wire logic [irq_agg_pkg::AUX_W-1:0] aux_sense_src,
    // Configuration and power state from same-clock logic
    input wire irq_agg_pkg::dbnc_cfg_t dbnc_cfg,
    input wire irq_agg_pkg::pwr_state_t pwr_state,
    // Interrupt pin
    output logic irq_out
);
    import irq_agg_pkg::*;

    localparam int RAW_W = EVENT_W + AUX_W + 1;

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Microseconds to oscillator ticks, rounded up
    function automatic logic [CNT_W-1:0] ticks(input int unsigned us);
        return CNT_W'((longint'(us) * OSC_HZ + US_PER_S - 1) / US_PER_S);
    endfunction

    function automatic reg_sel_t decode(input logic [APB_ADDR_W-1:0] a);
        unique case (a)
            STATUS_LO_OFS: return sel_status_lo;
            STATUS_HI_OFS: return sel_status_hi;
            MASK_LO_OFS: return sel_mask_lo;
            MASK_HI_OFS: return sel_mask_hi;
            SENSE_OFS: return sel_sense;
            default: return sel_none;
        endcase
    endfunction

    // Replace one 32-bit word of a widened event vector
    function automatic logic [EVENT_W-1:0] put_word(input logic [EVENT_W-1:0] v,
                                                    input logic hi,
                                                    input logic [WORD_W-1:0] d);
        logic [2*WORD_W-1:0] w;
        w = (2*WORD_W)'(v);
        if (hi) begin
            w[2*WORD_W-1:WORD_W] = d;
        end else begin
            w[WORD_W-1:0] = d;
        end
        return w[EVENT_W-1:0];
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [RAW_W-1:0] meta_ff;
    logic [RAW_W-1:0] sync_a_ff;
    logic [RAW_W-1:0] sync_b_ff;
    logic [RAW_W-1:0] live_ff;
    logic [RAW_W-1:0] disagree;
    logic [RAW_W-1:0] nxt_live;

    // Three stages; the first is only read by the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= '0;
            sync_a_ff <= '0;
            sync_b_ff <= '0;
        end else if (ce) begin
            meta_ff <= {osc32k_in, aux_sense_src, event_src};
            sync_a_ff <= meta_ff;
            sync_b_ff <= sync_a_ff;
        end
    end

    // A change counts only once the last two stages agree
    assign disagree = sync_a_ff ^ sync_b_ff;
    assign nxt_live = (sync_b_ff & ~disagree) | (live_ff & disagree);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            live_ff <= '0;
        end else if (ce) begin
            live_ff <= nxt_live;
        end
    end

    // ************************************************************
    // Oscillator tick and start-up priming
    // ************************************************************
    logic osc_prev_ff;
    logic tick_ff;
    logic [2:0] prime_cnt_ff;
    logic primed;

    // One-cycle tick per oscillator rising edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_prev_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            osc_prev_ff <= live_ff[RAW_W-1];
            tick_ff <= live_ff[RAW_W-1] & ~osc_prev_ff;
        end
    end

    // Hold off events until the pipeline holds real levels, so no false edge
    assign primed = (prime_cnt_ff == PRIME_CYCLES);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prime_cnt_ff <= '0;
        end else if (ce && !primed) begin
            prime_cnt_ff <= prime_cnt_ff + 3'h1;
        end
    end

    // ************************************************************
    // Per-source trigger and debounce selection
    // ************************************************************
    logic [CNT_W-1:0] thr_rise [EVENT_W];
    logic [CNT_W-1:0] thr_fall [EVENT_W];
    logic [EVENT_W-1:0] on_rise;
    logic [EVENT_W-1:0] on_fall;

    // Default is rising edge with no debounce
    always_comb begin
        for (int i = 0; i < EVENT_W; i++) begin
            thr_rise[i] = '0;
            thr_fall[i] = '0;
        end
        on_rise = '1;
        on_fall = '0;
        on_fall[touch_pen_event] = 1'b1;
        thr_rise[touch_pen_event] = ticks(PEN_DB_US);
        thr_fall[touch_pen_event] = ticks(PEN_DB_US);
        on_fall[vbus_overvoltage_event] = 1'b1;
        thr_rise[vbus_overvoltage_event] = ticks(PROG_DB_US[dbnc_cfg.overvoltage_debounce_sel]);
        thr_fall[vbus_overvoltage_event] = ticks(PROG_DB_US[dbnc_cfg.overvoltage_debounce_sel]);
        on_rise[battery_low_event] = 1'b0;
        on_fall[battery_low_event] = 1'b1;
        thr_fall[battery_low_event] = ticks(PROG_DB_US[dbnc_cfg.battery_low_debounce_sel]);
        on_fall[vbus_present_event] = 1'b1;
        thr_rise[vbus_present_event] = ticks(PROG_DB_US[dbnc_cfg.vbus_present_debounce_sel]);
        thr_fall[vbus_present_event] = ticks(PROG_DB_US[dbnc_cfg.vbus_present_debounce_sel]);
        // Shortest legal persistence is used; it stays inside the window
        thr_rise[regulator_short_event] = ticks(SHORT_DB_US);
        for (int b = 0; b < 2; b++) begin
            on_fall[button_one_event + b] = 1'b1;
            thr_rise[button_one_event + b] = ticks(BUTTON_DB_US);
            thr_fall[button_one_event + b] = ticks(BUTTON_DB_US
                + BUTTON_EXT_US[dbnc_cfg.button_falling_debounce_sel[b]]);
        end
        on_fall[osc_source_change_event] = 1'b1;
        for (int t = 0; t < TEMP_N; t++) begin
            on_fall[die_temp_first_event + t] = 1'b1;
            thr_rise[die_temp_first_event + t] = ticks(PROG_DB_US[dbnc_cfg.die_temp_debounce_sel]);
            thr_fall[die_temp_first_event + t] = ticks(PROG_DB_US[dbnc_cfg.die_temp_debounce_sel]);
        end
        // Pins set as outputs raise nothing
        for (int g = 0; g < GP_N; g++) begin
            on_rise[gp_pin_event + g] = dbnc_cfg.gp_is_input[g]
                && (dbnc_cfg.gp_trigger_sel[g] inside {rise_only, either_edge});
            on_fall[gp_pin_event + g] = dbnc_cfg.gp_is_input[g]
                && (dbnc_cfg.gp_trigger_sel[g] inside {fall_only, either_edge});
            thr_rise[gp_pin_event + g] = ticks(PROG_DB_US[dbnc_cfg.gp_debounce_sel[g]]);
            thr_fall[gp_pin_event + g] = ticks(PROG_DB_US[dbnc_cfg.gp_debounce_sel[g]]);
        end
    end

    // ************************************************************
    // Debounce and edge qualification
    // ************************************************************
    logic [CNT_W-1:0] cnt_ff [EVENT_W];
    logic [EVENT_W-1:0] qual_ff;
    logic [EVENT_W-1:0] nxt_qual;
    logic [EVENT_W-1:0] hit;

    // New level is accepted at once for zero debounce, else at count expiry
    always_comb begin
        logic [CNT_W-1:0] thr;
        thr = '0;
        nxt_qual = qual_ff;
        for (int i = 0; i < EVENT_W; i++) begin
            thr = live_ff[i] ? thr_rise[i] : thr_fall[i];
            if (live_ff[i] != qual_ff[i]) begin
                if (thr == '0 || (tick_ff && (cnt_ff[i] + CNT_W'(1)) >= thr)) begin
                    nxt_qual[i] = live_ff[i];
                end
            end
        end
        hit = (nxt_qual & ~qual_ff & on_rise) | (~nxt_qual & qual_ff & on_fall);
        if (!primed) begin
            hit = '0;
        end
    end

    // Counter restarts whenever the level falls back before expiry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < EVENT_W; i++) begin
                cnt_ff[i] <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < EVENT_W; i++) begin
                if (live_ff[i] == qual_ff[i] || nxt_qual[i] != qual_ff[i]) begin
                    cnt_ff[i] <= '0;
                end else if (tick_ff) begin
                    cnt_ff[i] <= cnt_ff[i] + CNT_W'(1);
                end
            end
        end
    end

    // Qualified level tracks the raw one until primed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            qual_ff <= '0;
        end else if (ce) begin
            qual_ff <= primed ? nxt_qual : nxt_live[EVENT_W-1:0];
        end
    end

    // ************************************************************
    // Live sense vector
    // ************************************************************
    logic [SENSE_W-1:0] sense;

    // Straight from the synchronised sources, never latched
    always_comb begin
        sense = '0;
        sense[vbus_overvoltage_sense] = live_ff[vbus_overvoltage_event];
        sense[vbus_present_sense] = live_ff[vbus_present_event];
        sense[button_one_sense] = live_ff[button_one_event];
        sense[button_two_sense] = live_ff[button_two_event];
        sense[osc_source_crystal_sense] = live_ff[osc_source_change_event];
        for (int k = 0; k < AUX_W; k++) begin
            sense[adc_result_sense + k] = live_ff[EVENT_W + k];
        end
        for (int t = 0; t < TEMP_N; t++) begin
            sense[die_temp_first_sense + t] = live_ff[die_temp_first_event + t];
        end
        for (int g = 0; g < GP_N; g++) begin
            sense[gp_pin_sense + g] = live_ff[gp_pin_event + g];
        end
    end

    // ************************************************************
    // APB slave
    // ************************************************************
    logic access;
    logic commit;
    logic regs_open;
    logic do_write;
    reg_sel_t sel;
    logic [WORD_W-1:0] rd_word;
    logic [EVENT_W-1:0] status_ff;
    logic [EVENT_W-1:0] mask_ff;
    logic [EVENT_W-1:0] clr;

    assign access = apb_req.psel & apb_req.penable;
    assign commit = access & apb_rsp.pready;
    assign regs_open = pwr_state inside {watchdog, on_state, user_off_wait};
    assign sel = decode(apb_req.paddr);
    assign do_write = commit & apb_req.pwrite & regs_open;

    // Read mux over the mapped words
    always_comb begin
        unique case (sel)
            sel_status_lo: rd_word = WORD_W'(status_ff);
            sel_status_hi: rd_word = WORD_W'((2*WORD_W)'(status_ff) >> WORD_W);
            sel_mask_lo: rd_word = WORD_W'(mask_ff);
            sel_mask_hi: rd_word = WORD_W'((2*WORD_W)'(mask_ff) >> WORD_W);
            sel_sense: rd_word = WORD_W'(sense);
            default: rd_word = '0;
        endcase
    end

    // One wait state; errors for unmapped or closed state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            apb_rsp <= '0;
        end else if (ce) begin
            if (access && !apb_rsp.pready) begin
                apb_rsp.pready <= 1'b1;
                apb_rsp.pslverr <= !regs_open || sel == sel_none;
                apb_rsp.prdata <= (regs_open && !apb_req.pwrite) ? rd_word : '0;
            end else begin
                apb_rsp.pready <= 1'b0;
                apb_rsp.pslverr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Status, mask and interrupt pin
    // ************************************************************
    // Write-one-to-clear; a sense write hits no storage
    always_comb begin
        clr = '0;
        if (do_write && sel == sel_status_lo) begin
            clr = put_word('0, 1'b0, apb_req.pwdata);
        end else if (do_write && sel == sel_status_hi) begin
            clr = put_word('0, 1'b1, apb_req.pwdata);
        end
    end

    // Set wins over a clear in the same cycle; masks do not gate latching
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_ff <= '0;
        end else if (ce) begin
            status_ff <= (status_ff & ~clr) | hit;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= MASK_RESET[EVENT_W-1:0];
        end else if (ce && do_write) begin
            if (sel == sel_mask_lo) begin
                mask_ff <= put_word(mask_ff, 1'b0, apb_req.pwdata);
            end else if (sel == sel_mask_hi) begin
                mask_ff <= put_word(mask_ff, 1'b1, apb_req.pwdata);
            end
        end
    end

    // Pin forced low outside the running states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_out <= 1'b0;
        end else if (ce) begin
            irq_out <= (pwr_state inside {watchdog, on_state})
                && |(status_ff & ~mask_ff);
        end
    end

endmodule
`default_nettype wire

// ==== pmic_event_irq_aggregator_bench.sv ====
// Bench: drives sources and power state, checks registers and the pin
`timescale 1ns/1ps
`default_nettype none
module pmic_event_irq_aggregator_bench;
    import irq_agg_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic osc32k_in = 1'b0;
    logic [3:0] osc_div = 4'h0;
    logic [EVENT_W-1:0] event_src = '0;
    logic [AUX_W-1:0] aux_sense_src = '0;
    pwr_state_t pwr_state = on_state;
    dbnc_cfg_t dbnc_cfg = '0;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    logic irq_out;
    logic [31:0] rdat;
    logic rerr;
    int miscompares = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    // Slow tick, 16 clocks per half period
    always @(posedge clk) begin
        osc_div <= osc_div + 4'h1;
        if (osc_div == 4'hf) begin
            osc32k_in <= ~osc32k_in;
        end
    end
    pmic_event_irq_aggregator DUT (.clk(clk), .resetn(resetn), .ce(1'b1), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .osc32k_in(osc32k_in), .event_src(event_src),
        .aux_sense_src(aux_sense_src), .dbnc_cfg(dbnc_cfg), .pwr_state(pwr_state),
        .irq_out(irq_out));
    ap_bus_model host (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));
    // ********
    // Shared tasks
    // ********
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        host.xfer(1'b0, a, 32'h0, rdat, rerr);
        check("prdata", exp, rdat);
        check("pslverr", {31'h0, e}, {31'h0, rerr});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdat, rerr);
    endtask
    // Source moves, then enough clocks for sync and latch
    task automatic ev(input int b, input logic v);
        @(posedge clk);
        event_src[b] <= v;
        repeat (10) @(posedge clk);
    endtask
    task automatic pin(input logic exp);
        repeat (3) @(posedge clk);
        check("irq_out", {31'h0, exp}, {31'h0, irq_out});
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // ********
    // Test sequence
    // ********
    initial begin
        // Levels already high at reset must not latch anything
        event_src[battery_low_event] = 1'b1;
        event_src[key_jam_event] = 1'b1;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        pin(1'b0);
        rd(MASK_LO_OFS, 32'hffffffff, 1'b0);
        rd(MASK_HI_OFS, 32'h00000007, 1'b0);
        rd(STATUS_LO_OFS, 32'h0, 1'b0);
        ev(adc_finished_event, 1'b1);
        rd(STATUS_LO_OFS, 32'h1, 1'b0);
        pin(1'b0);
        wr(MASK_LO_OFS, 32'hfffefffe);
        pin(1'b1);
        ev(second_tick_event, 1'b1);
        wr(STATUS_LO_OFS, 32'h1);
        pin(1'b1);
        rd(STATUS_LO_OFS, 32'h00010000, 1'b0);
        pwr_state <= user_off_wait;
        pin(1'b0);
        rd(STATUS_LO_OFS, 32'h00010000, 1'b0);
        pwr_state <= off_state;
        rd(STATUS_LO_OFS, 32'h0, 1'b1);
        wr(STATUS_LO_OFS, 32'h00010000);
        pwr_state <= on_state;
        pin(1'b1);
        wr(STATUS_LO_OFS, 32'h00010000);
        pin(1'b0);
        ev(battery_low_event, 1'b0);
        rd(STATUS_LO_OFS, 32'h10, 1'b0);
        wr(STATUS_LO_OFS, 32'h10);
        ev(battery_low_event, 1'b1);
        rd(STATUS_LO_OFS, 32'h0, 1'b0);
        aux_sense_src <= 5'h15;
        ev(vbus_present_event, 1'b1);
        rd(STATUS_LO_OFS, 32'h20, 1'b0);
        // Pen needs 33 oscillator ticks of 32 clocks before it latches
        ev(touch_pen_event, 1'b1);
        rd(STATUS_LO_OFS, 32'h20, 1'b0);
        repeat (1150) @(posedge clk);
        rd(STATUS_LO_OFS, 32'h24, 1'b0);
        // First general pin as input, falling edge only
        dbnc_cfg.gp_is_input <= 4'h1;
        dbnc_cfg.gp_trigger_sel[0] <= fall_only;
        ev(gp_pin_event, 1'b1);
        rd(STATUS_LO_OFS, 32'h24, 1'b0);
        ev(gp_pin_event, 1'b0);
        rd(STATUS_LO_OFS, 32'h80000024, 1'b0);
        rd(SENSE_OFS, 32'h2a2, 1'b0);
        wr(SENSE_OFS, 32'h0);
        rd(SENSE_OFS, 32'h2a2, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== pmic_event_irq_aggregator_sva.sv ====
// Checker: bus handshake, error answers and interrupt gating
`timescale 1ns/1ps
`default_nettype none
module pmic_event_irq_aggregator_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Bus, power state and pin
    input wire irq_agg_pkg::apb_req_t apb_req,
    input wire irq_agg_pkg::apb_rsp_t apb_rsp,
    input wire irq_agg_pkg::pwr_state_t pwr_state,
    input wire logic irq_out
);
    import irq_agg_pkg::*;
    // ********
    // Properties on the bus clock
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    irq_gate_a: assert property (
        ce && !(pwr_state inside {watchdog, on_state}) |=> !irq_out)
        else $error("irq high in a quiet state");
    irq_cause_a: assert property (
        $rose(irq_out) |-> $past(pwr_state) inside {watchdog, on_state})
        else $error("irq rose in a quiet state");
    ready_wait_a: assert property (
        ce && apb_req.psel && apb_req.penable && !$past(apb_req.penable) |=> apb_rsp.pready)
        else $error("no answer after one wait state");
    ready_pulse_a: assert property (ce && apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
        else $error("pready without access");
    state_err_a: assert property (
        apb_rsp.pready && !($past(pwr_state) inside {watchdog, on_state, user_off_wait})
        |-> apb_rsp.pslverr) else $error("access allowed in a closed state");
    map_err_a: assert property (
        apb_rsp.pready && $past(apb_req.paddr) > SENSE_OFS |-> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    err_zero_a: assert property (
        apb_rsp.pready && apb_rsp.pslverr && !$past(apb_req.pwrite) |-> apb_rsp.prdata == '0)
        else $error("refused read data not zero");
    rdata_hold_a: assert property (!apb_rsp.pready |-> $stable(apb_rsp.prdata))
        else $error("prdata moved between answers");
endmodule
bind pmic_event_irq_aggregator pmic_event_irq_aggregator_sva sva_i (.clk(clk), .resetn(resetn),
    .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .pwr_state(pwr_state), .irq_out(irq_out));
`default_nettype wire
